// [io_bus_chan.sv]
// Purpose: Peripheral end of a minicomputer I/O bus for a disc controller
// Assumes: Bus pins asynchronous to pclk, strobes wide against 100 ns clock
// Notes: Disc datapath outside; this block holds flags, chain and words
//
// Contract
// - Read assembles 16 serial bits, buffers into data register, drives on DATIA.
// - After last of 256 read words reaches processor, assert done.
// - Subsector mode loads length counter from data bits 04-15.
// - MSKI sets or clears interrupt disable from assigned data bit.
// - Completing an operation sets the done flag.
// - Done and not disabled sets interrupt request at RQENB leading edge.
// - Pass INTP onward only while interrupt request is clear.
// - INTA with INTP and request set drives device code on lines 10-15.
// - Clearing done clears interrupt request and drops INTR; CLR or IOPLS in the same cycle as an RQENB edge with done set still raises it.
// - Pass DCHP onward only while channel request is clear.
// - Word ready sets channel request at RQENB edge, asserting DCHR.
// - DCHA edge selects device with DCHP and request; others deselect.
// - Selected device drives memory address on lines 1-15 during DCHA.
// - While selected, DCHMO low for read, high for write.
// - DCHA leading edge clears the word-ready flag.
// - Input transfer keeps data register driven until DCHI falls.
// - Output transfer loads data register on DCHO.
// - RQENB after a channel access deasserts DCHR.
// - Serviced device keeps request at RQENB only if word ready again.
// - IOPLS write command sets write op, busy, clears done, starts.
// - Respond to I/O controls only when select code matches; MSKI is taken whatever the select code.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module io_bus_chan
  import io_bus_chan_pkg::*;
#(
  // Arbitrary default select code, octal 20
  parameter logic [5:0] DEV_CODE = 6'h10,
  parameter int MASK_BIT = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor strobes, asynchronous
  input wire logic [io_bus_chan_pkg::NPIN-1:0] strobe_in,
  input wire logic [io_bus_chan_pkg::CODE_W-1:0] dev_sel_in,
  // Data lines, split into three signals
  input wire logic [io_bus_chan_pkg::WORD_W-1:0] data_in,
  output logic [io_bus_chan_pkg::WORD_W-1:0] data_out,
  output logic [io_bus_chan_pkg::WORD_W-1:0] data_oe,
  // Requests and priority chain toward the processor
  output logic intr,
  output logic dchr,
  output logic intp_out,
  output logic dchp_out,
  output logic dchmo,
  output logic dchmo_oe,
  output logic done_to_cpu,
  output logic busy_to_cpu,
  // Disc side, same clock
  input wire logic disc_bit,
  input wire logic disc_bit_valid,
  output logic disc_word_valid,
  output logic [io_bus_chan_pkg::WORD_W-1:0] disc_word,
  output logic start
);
  import io_bus_chan_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [WORD_W-1:0] d1;
    logic [WORD_W-1:0] d2;
    logic [CODE_W-1:0] c1;
    logic [CODE_W-1:0] c2;
    logic [WORD_W-1:0] shift;
    logic [3:0] bits;
    logic [WORD_W-1:0] wbuf;
    logic wbuf_full;
    logic [WORD_W-1:0] data_reg;
    logic data_full;
    logic [WORD_W-1:0] mem_addr;
    logic [WORD_W-1:0] count;
    logic sub_loaded;
    logic cmd_write;
    logic done;
    logic busy;
    logic write_op_ff;
    logic disable_ff;
    logic int_req;
    logic chan_request_ff;
    logic chan_selected_ff;
    logic chan_word_ready_ff;
    logic serviced;
    logic [WORD_W-1:0] dout;
    logic [WORD_W-1:0] doe;
    logic intp_o;
    logic dchp_o;
    logic dchmo_oe;
    logic [31:0] rdata;
    logic slverr;
    logic ready;
    logic wvalid;
    logic [WORD_W-1:0] wword;
    logic start;
  } state_t;

  state_t r;
  state_t next_r;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic hit;
  logic last;
  logic [31:0] status;

  always_comb begin
    rise = r.s2 & ~r.s3;
    fall = ~r.s2 & r.s3;
    hit = (r.c2 == DEV_CODE);
    last = (r.count == RESET_WORD);
    status = 32'h0000_0000;
    status[ST_DONE] = r.done;
    status[ST_BUSY] = r.busy;
    status[ST_INT_REQ] = r.int_req;
    status[ST_CHAN_REQ] = r.chan_request_ff;
    status[ST_CHAN_SEL] = r.chan_selected_ff;
    status[ST_WORD_READY] = r.chan_word_ready_ff;
    status[ST_WRITE_OP] = r.write_op_ff;
    status[ST_DISABLE] = r.disable_ff;
    status[ST_SUBSECTOR] = r.sub_loaded;
  end

  always_comb begin
    next_r = r;
    // Second and third stages feed logic; first stage only feeds second
    next_r.s1 = strobe_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.d1 = data_in;
    next_r.d2 = r.d1;
    next_r.c1 = dev_sel_in;
    next_r.c2 = r.c1;
    next_r.wvalid = 1'b0;
    next_r.start = 1'b0;
    next_r.ready = 1'b1;

    if (disc_bit_valid && !r.write_op_ff && r.busy) begin
      next_r.shift = {r.shift[WORD_W-2:0], disc_bit};
      next_r.bits = r.bits + 4'h1;
      if (r.bits == LAST_BIT) begin
        next_r.wbuf = {r.shift[WORD_W-2:0], disc_bit};
        next_r.wbuf_full = 1'b1;
      end
    end
    if (r.wbuf_full && !r.data_full && !r.write_op_ff) begin
      next_r.data_reg = r.wbuf;
      next_r.data_full = 1'b1;
      next_r.wbuf_full = 1'b0;
      next_r.chan_word_ready_ff = 1'b1;
    end
    // Write: ask for a word once the last one has gone to the disc side;
    // a serviced request may be renewed before its RQENB arrives
    if (r.busy && r.write_op_ff && !r.data_full &&
        !r.chan_word_ready_ff && !r.chan_selected_ff &&
        (!r.chan_request_ff || r.serviced)) begin
      next_r.chan_word_ready_ff = 1'b1;
    end
    // Disc side drains the write word next cycle
    if (r.write_op_ff && r.data_full && !r.chan_selected_ff) begin
      next_r.wword = r.data_reg;
      next_r.wvalid = 1'b1;
      next_r.data_full = 1'b0;
    end

    // I/O instruction controls
    if (hit && rise[P_DATOB]) begin
      next_r.mem_addr = r.d2;
    end
    if (hit && rise[P_DATOC]) begin
      next_r.count = {r.d2[LEN_W-1:0], 4'h0};
      next_r.sub_loaded = 1'b1;
    end
    if (rise[P_MSKI]) begin
      next_r.disable_ff = r.d2[MASK_BIT];
    end
    if (hit && rise[P_IOPLS]) begin
      next_r.write_op_ff = r.cmd_write;
      next_r.busy = 1'b1;
      next_r.done = 1'b0;
      next_r.int_req = 1'b0;
      next_r.start = 1'b1;
      next_r.bits = RESET_BITS;
      next_r.sub_loaded = 1'b0;
      if (!r.sub_loaded) begin
        next_r.count = SECTOR_LOAD;
      end
    end
    if (hit && rise[P_CLR]) begin
      next_r.done = 1'b0;
      next_r.busy = 1'b0;
      next_r.int_req = 1'b0;
    end

    if (rise[P_RQENB] && r.done && !r.disable_ff) begin
      next_r.int_req = 1'b1;
    end
    if (rise[P_RQENB]) begin
      if (r.serviced) begin
        next_r.chan_request_ff = r.chan_word_ready_ff;
        next_r.serviced = 1'b0;
      end else if (r.chan_word_ready_ff) begin
        next_r.chan_request_ff = 1'b1;
      end
    end

    if (rise[P_DCHA]) begin
      next_r.chan_selected_ff = r.s2[P_DCHP] & r.chan_request_ff;
      if (r.s2[P_DCHP] && r.chan_request_ff) begin
        next_r.serviced = 1'b1;
        next_r.count = r.count + 16'h0001;
        next_r.chan_word_ready_ff = 1'b0;
      end
    end
    // Address advances after DCHA ends, so the lines show the current one
    if (fall[P_DCHA] && r.chan_selected_ff) begin
      next_r.mem_addr = r.mem_addr + 16'h0001;
    end
    // input word taken when DCHI ends
    if (fall[P_DCHI] && r.chan_selected_ff && !r.write_op_ff) begin
      next_r.data_full = 1'b0;
      next_r.chan_selected_ff = 1'b0;
      if (last) begin
        next_r.done = 1'b1;
        next_r.busy = 1'b0;
      end
    end
    if (rise[P_DCHO] && r.chan_selected_ff && r.write_op_ff) begin
      next_r.data_reg = r.d2;
      next_r.data_full = 1'b1;
      next_r.chan_selected_ff = 1'b0;
      if (last) begin
        next_r.done = 1'b1;
        next_r.busy = 1'b0;
      end
    end

    next_r.intp_o = r.s2[P_INTP] & ~next_r.int_req;
    next_r.dchp_o = r.s2[P_DCHP] & ~next_r.chan_request_ff;
    next_r.dchmo_oe = next_r.chan_selected_ff;

    next_r.dout = RESET_WORD;
    next_r.doe = RESET_WORD;
    if (r.s2[P_INTA] && r.s2[P_INTP] && r.int_req) begin
      next_r.dout = {10'h000, DEV_CODE};
      next_r.doe = 16'h003F;
    end else if (r.s2[P_DCHA] && r.chan_selected_ff) begin
      next_r.dout = {1'b0, r.mem_addr[14:0]};
      next_r.doe = 16'h7FFF;
    end else if ((r.s2[P_DCHI] && r.chan_selected_ff) ||
                 (hit && r.s2[P_DATIA])) begin
      // data register held on the lines
      next_r.dout = r.data_reg;
      next_r.doe = 16'hFFFF;
    end

    // APB: answer in the access phase, no wait states
    if (psel && !penable) begin
      next_r.slverr = 1'b0;
      next_r.rdata = 32'h0000_0000;
      case (paddr)
        OFF_CTRL: next_r.rdata = {31'h0, r.cmd_write};
        OFF_STATUS: next_r.rdata = status;
        OFF_ADDR: next_r.rdata = {16'h0000, r.mem_addr};
        OFF_COUNT: next_r.rdata = {16'h0000, r.count};
        default: next_r.slverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && paddr == OFF_CTRL) begin
      next_r.cmd_write = pwdata[CTRL_WRITE];
      if (pwdata[CTRL_CLEAR]) begin
        next_r.done = 1'b0;
        next_r.int_req = 1'b0;
      end
    end
  end

  // reset clears flags and releases lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pready = r.ready;
  assign pslverr = r.slverr;
  assign data_out = r.dout;
  assign data_oe = r.doe;
  assign intr = r.int_req;
  assign dchr = r.chan_request_ff;
  assign intp_out = r.intp_o;
  assign dchp_out = r.dchp_o;
  assign dchmo = r.write_op_ff;
  assign dchmo_oe = r.dchmo_oe;
  assign done_to_cpu = r.done;
  assign busy_to_cpu = r.busy;
  assign disc_word_valid = r.wvalid;
  assign disc_word = r.wword;
  assign start = r.start;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_int_set;
    rise[P_RQENB] && r.done && !r.disable_ff && !(hit && rise[P_CLR])
      |=> intr;
  endproperty
  a_int_set: assert property (p_int_set)
    else $error("interrupt request not raised");

  property p_intp_block;
    intr |-> !intp_out;
  endproperty
  a_intp_block: assert property (p_intp_block)
    else $error("INTP passed while requesting");

  property p_dchp_block;
    r.chan_request_ff && next_r.chan_request_ff |=> !dchp_out;
  endproperty
  a_dchp_block: assert property (p_dchp_block)
    else $error("DCHP passed while requesting");

  property p_clear_done;
    hit && rise[P_CLR] && !rise[P_RQENB] |=> !intr && !done_to_cpu;
  endproperty
  a_clear_done: assert property (p_clear_done)
    else $error("clear left request standing");

  property p_ready_clear;
    rise[P_DCHA] && r.s2[P_DCHP] && r.chan_request_ff
      |=> !r.chan_word_ready_ff && r.chan_selected_ff;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("DCHA did not select or clear ready");

  property p_addr_drive;
    r.s2[P_DCHA] && r.chan_selected_ff && !(r.s2[P_INTA] && r.s2[P_INTP])
      |=> data_oe == 16'h7FFF && data_out[14:0] == $past(r.mem_addr[14:0]);
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("address not driven during DCHA");

  property p_repeat;
    rise[P_RQENB] && r.serviced |=> dchr == $past(r.chan_word_ready_ff);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat request wrong");

  property p_start;
    hit && rise[P_IOPLS] && !rise[P_CLR] |=> busy_to_cpu && !done_to_cpu
      && start && (r.write_op_ff == $past(r.cmd_write));
  endproperty
  a_start: assert property (p_start)
    else $error("command start wrong");

  property p_dchmo;
    r.chan_selected_ff |-> dchmo_oe && (dchmo == r.write_op_ff);
  endproperty
  a_dchmo: assert property (p_dchmo)
    else $error("DCHMO not driven while selected");

  c_intr: cover property (rise[P_RQENB] ##[1:20] intr);
  c_read_done: cover property (fall[P_DCHI] && last ##1 done_to_cpu);
  c_write_word: cover property (rise[P_DCHO] ##[1:4] disc_word_valid);
  c_repeat: cover property (rise[P_RQENB] && r.serviced
                            && r.chan_word_ready_ff);
endmodule // io_bus_chan

// [io_bus_chan_pkg.sv]
// Purpose: Shared constants for the I/O bus interrupt and data channel block
// Assumes: APB register window, 32-bit data, one aligned word per register
// Notes: Pin indices address the synchronised strobe vector
package io_bus_chan_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  // Control register fields
  localparam int CTRL_WRITE = 0;
  localparam int CTRL_CLEAR = 1;
  // Status register fields
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_INT_REQ = 2;
  localparam int ST_CHAN_REQ = 3;
  localparam int ST_CHAN_SEL = 4;
  localparam int ST_WORD_READY = 5;
  localparam int ST_WRITE_OP = 6;
  localparam int ST_DISABLE = 7;
  localparam int ST_SUBSECTOR = 8;
  // Strobe pin positions in the synchronised vector
  localparam int P_RQENB = 0;
  localparam int P_DCHA = 1;
  localparam int P_DCHI = 2;
  localparam int P_DCHO = 3;
  localparam int P_INTA = 4;
  localparam int P_INTP = 5;
  localparam int P_DCHP = 6;
  localparam int P_MSKI = 7;
  localparam int P_DATOB = 8;
  localparam int P_DATIA = 9;
  localparam int P_IOPLS = 10;
  localparam int P_CLR = 11;
  localparam int P_DATOC = 12;
  localparam int NPIN = 13;
  // Bus geometry
  localparam int WORD_W = 16;
  localparam int CODE_W = 6;
  localparam int LEN_W = 12;
  localparam int SUB_SHIFT = 4;
  // Full sector, as a negative word count: 256 words
  localparam logic [15:0] SECTOR_LOAD = 16'hFF00;
  // Reset values and last bit count
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0] RESET_BITS = 4'h0;
  localparam logic [3:0] LAST_BIT = 4'hF;
endpackage

// [proc_bus_model.sv]
// Purpose: Processor end of the I/O bus, drives strobes and data lines
// Assumes: Strobes held six cycles, twice the three-cycle minimum
// Notes: Undriven data lines toggle, so a stale word cannot pass
`timescale 1ns/100ps
module proc_bus_model (
  // Clock
  input wire logic pclk,
  // Select code to present
  input wire logic [5:0] code,
  // Bus toward the block
  output logic [io_bus_chan_pkg::NPIN-1:0] strobe_in,
  output logic [5:0] dev_sel_in,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe
);
  import io_bus_chan_pkg::*;
  logic [15:0] pdata = 16'h0000;
  logic pdrv = 1'b0;
  logic [15:0] last = 16'h0000;
  logic [15:0] seen = 16'h0000;
  // Both priority chains held granted toward the block
  initial strobe_in = 13'h0060;
  assign dev_sel_in = code;
  assign data_in = (data_oe & data_out) | (~data_oe & (pdrv ? pdata : ~last));
  always @(posedge pclk) last <= data_in;

  task automatic pulse(input int pin, input logic [15:0] d = 16'h0000);
    @(posedge pclk);
    pdrv <= pin inside {P_MSKI, P_DATOB, P_DATOC, P_DCHO};
    pdata <= d;
    strobe_in[pin] <= 1'b1;
    repeat (6) @(posedge pclk);
    seen = data_in;
    strobe_in[pin] <= 1'b0;
    repeat (6) @(posedge pclk);
    pdrv <= 1'b0;
  endtask
endmodule // proc_bus_model

// [io_bus_interrupt_data_channel_tb_top.sv]
// Purpose: Self-checking bench for the I/O bus interrupt and channel block
// Assumes: Block answers a pin change within four edges
// Notes: Driver queues expectations, monitors compare them
`timescale 1ns/100ps
module io_bus_interrupt_data_channel_tb_top;
  import io_bus_chan_pkg::*;
  typedef struct {int sel; logic [32:0] exp; logic [32:0] mask;} note_t;
  localparam logic [5:0] CODE = 6'h10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, intr, dchr, intp_out, dchp_out, dchmo, dchmo_oe;
  logic done_to_cpu, busy_to_cpu;
  logic [12:0] strobe_in;
  logic [5:0] dev_sel_in;
  logic [5:0] code = 6'h10;
  logic [15:0] data_in, data_out, data_oe, disc_word, w, a;
  logic disc_bit = 1'b0;
  logic disc_bit_valid = 1'b0;
  int n_mismatch = 0;
  int n_compared = 0;
  note_t qpin[$], qreg[$], np, nr;
  event look;
  always #50 pclk = ~pclk;

  io_bus_chan #(.DEV_CODE(CODE), .MASK_BIT(8)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .strobe_in, .dev_sel_in, .data_in, .data_out,
    .data_oe, .intr, .dchr, .intp_out, .dchp_out, .dchmo, .dchmo_oe,
    .done_to_cpu, .busy_to_cpu, .disc_bit, .disc_bit_valid,
    .disc_word_valid(), .disc_word, .start());
  proc_bus_model proc (
    .pclk, .code, .strobe_in, .dev_sel_in, .data_in, .data_out, .data_oe);

  function automatic logic [32:0] obs(int sel);
    case (sel)
      0: return {25'h0, intr, dchr, intp_out, dchp_out, dchmo, dchmo_oe,
                 done_to_cpu, busy_to_cpu};
      1: return {17'h0, data_oe};
      2: return {17'h0, disc_word};
      default: return {17'h0, proc.seen};
    endcase
  endfunction
  task automatic cmp_pin(note_t n, logic [32:0] s);
    n_compared++;
    if ((s & n.mask) !== n.exp) begin
      n_mismatch++;
      $display("wrong value pins %0d expected %h seen %h", n.sel, n.exp, s);
    end
  endtask
  task automatic cmp_reg(note_t n, logic [32:0] s);
    n_compared++;
    if ((s & n.mask) !== n.exp) begin
      n_mismatch++;
      $display("wrong value register expected %h seen %h", n.exp, s);
    end
  endtask
  always @(look) begin
    while (qpin.size() > 0) begin
      np = qpin.pop_front();
      cmp_pin(np, obs(np.sel));
    end
  end
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && qreg.size() > 0) begin
      nr = qreg.pop_front();
      cmp_reg(nr, {pslverr, prdata});
    end
  end

  task automatic chk(int sel, logic [32:0] e, logic [32:0] m);
    #1;
    qpin.push_back('{sel, e, m});
    -> look;
  endtask
  task automatic apb(logic wr, logic [7:0] ad, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, logic [32:0] e, logic [32:0] m);
    qreg.push_back('{0, e, m});
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic disc(logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(posedge pclk);
      disc_bit <= v[i];
      disc_bit_valid <= 1'b1;
    end
    @(posedge pclk);
    disc_bit_valid <= 1'b0;
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    complete_run;
  end

  initial begin
    void'($urandom(13));
    repeat (7) @(posedge pclk);
    chk(0, 33'h0, 33'hFF); // flags low in reset
    chk(1, 33'h0, 33'hFFFF); // data lines released
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(0, 33'h30, 33'hFF); // both chains pass
    rd(OFF_STATUS, 33'h0, 33'h1FFFFFFFF); // status clear
    rd(8'h10, 33'h100000000, 33'h100000000); // unmapped place refused
    @(posedge pclk);
    code <= 6'h11;
    proc.pulse(P_IOPLS);
    chk(0, 33'h0, 33'h1); // foreign code ignored
    @(posedge pclk);
    code <= CODE;
    apb(1'b1, OFF_CTRL, 32'h0);
    proc.pulse(P_IOPLS);
    chk(0, 33'h1, 33'h3); // busy, not done
    w = 16'($urandom);
    disc(w);
    proc.pulse(P_RQENB);
    chk(0, 33'h40, 33'h50); // request blocks chain
    proc.pulse(P_DCHA);
    chk(0, 33'h04, 33'h0C); // read level on mode line
    rd(OFF_STATUS, 33'h10, 33'h30); // selected, ready taken
    proc.pulse(P_DCHI);
    chk(3, {17'h0, w}, 33'hFFFF); // word held to strobe end
    proc.pulse(P_DATIA);
    chk(3, {17'h0, w}, 33'hFFFF); // assembled word on read strobe
    proc.pulse(P_RQENB);
    chk(0, 33'h00, 33'h40); // request dropped
    proc.pulse(P_CLR);
    apb(1'b1, OFF_CTRL, 32'h1);
    a = 16'($urandom) & 16'h7FFF;
    proc.pulse(P_DATOC, 16'h0FFF);
    proc.pulse(P_DATOB, a);
    proc.pulse(P_IOPLS);
    chk(0, 33'h1, 33'h3); // busy set, done cleared
    rd(OFF_STATUS, 33'h040, 33'h140); // write op, subsector flag cleared by start
    for (int k = 0; k < 16; k++) begin
      proc.pulse(P_RQENB);
      proc.pulse(P_DCHA);
      if (k == 0) begin
        chk(3, {17'h0, a}, 33'h7FFF); // address on lines 1-15
        chk(0, 33'h0C, 33'h0C); // write level on mode line
      end
      w = 16'($urandom);
      proc.pulse(P_DCHO, w);
      chk(2, {17'h0, w}, 33'hFFFF); // word taken on output strobe
    end
    chk(0, 33'h2, 33'h3); // done after one subsector
    proc.pulse(P_MSKI, 16'h0100);
    proc.pulse(P_RQENB);
    chk(0, 33'h20, 33'hA0); // masked, chain passes
    proc.pulse(P_MSKI, 16'h0000);
    proc.pulse(P_RQENB);
    chk(0, 33'h80, 33'hA0); // request stops chain
    proc.pulse(P_INTA);
    chk(3, {27'h0, CODE}, 33'h3F); // code on lines 10-15
    proc.pulse(P_CLR);
    chk(0, 33'h20, 33'hA2); // request and done cleared
    complete_run;
  end
endmodule // io_bus_interrupt_data_channel_tb_top
